// File: include/hsm_defines.svh
// Constants for the hot swap monitor readback block
`ifndef HSM_DEFINES_SVH
`define HSM_DEFINES_SVH
// Extended register select codes (low two bits of an extended write)
`define HSM_SEL_ALERT_EN   2'h1
`define HSM_SEL_ALERT_TH   2'h2
`define HSM_SEL_CONTROL    2'h3
// Command byte fields
`define HSM_CMD_EXT_BIT    7
`define HSM_CMD_V_CONT     0
`define HSM_CMD_V_ONCE     1
`define HSM_CMD_I_CONT     2
`define HSM_CMD_I_ONCE     3
`define HSM_CMD_RANGE      4
`define HSM_CMD_STATUS_RD  6
`define HSM_CMD_RESET      7'h00
// Alert enable fields
`define HSM_AEN_OC1        0
`define HSM_AEN_OC4        1
`define HSM_AEN_HS         2
`define HSM_AEN_OFF        3
`define HSM_AEN_CLEAR      4
`define HSM_AEN_RESET      5'h04
// Alert threshold and control resets
`define HSM_ATH_RESET      8'hFF
`define HSM_CTL_SOFTWARE_FORCE_OFF      0
`define HSM_CTL_RESET      8'h00
// Status byte positions
`define HSM_ST_DIGITAL_OVERCURRENT_LIVE      0
`define HSM_ST_ADC_ALERT   1
`define HSM_ST_ANALOG_OVERCURRENT_OFF       2
`define HSM_ST_SWAP_FAILURE_STICKY    3
`define HSM_ST_OFF         4
`define HSM_ST_OFF_ALERT   5
// Sticky flag indices
`define HSM_FLAG_ADC       0
`define HSM_FLAG_HS        1
`define HSM_FLAG_OFF       2
`define HSM_NUM_FLAGS      3
// Serial bus default address
`define HSM_SLAVE_ADDR     7'h40
`endif

// File: include/hsm_pkg.sv
// Types for the hot swap monitor readback block
package hsm_pkg;
  // Serial slave states
  typedef enum logic [2:0] {
    HSM_IDLE, HSM_ADDR, HSM_ACK, HSM_WR, HSM_RD, HSM_RDACK
  } hsm_state_t;
  // Whole state of the main module
  typedef struct packed {
    hsm_state_t  st;
    logic        sclQ;
    logic        sdaQ;
    logic [7:0]  shift;
    logic [3:0]  bitCnt;
    logic        rw;
    logic        wrIdx;
    logic [1:0]  extSel;
    logic [1:0]  rdIdx;
    logic        sdaOeN;
    logic [6:0]  cmd;
    logic [4:0]  alertEn;
    logic [7:0]  alertTh;
    logic        software_force_off;
    logic [11:0] vData;
    logic [11:0] iData;
    logic        vValid;
    logic        iValid;
    logic        onceBusy;
    logic [2:0]  ocHist;
    logic        offPrev;
    logic        hotSwapOn;
    logic        adcOc;
  } hsm_core_t;
  // State of one sticky flag
  typedef struct packed {
    logic flag;
  } hsm_flag_t;
endpackage

// File: include/hsm_flag_if.sv
// Set, clear and value of one sticky status flag
`timescale 1ns/1ps
interface hsm_flag_if;
  logic set;   // Event raises flag
  logic clr;   // Software clear
  logic flag;  // Current value
  modport owner (input set, input clr, output flag);
  modport user  (output set, output clr, input flag);
endinterface

// File: src/hsm_sticky_flag.sv
// One sticky status flag, set wins over clear
`timescale 1ns/1ps
`include "hsm_defines.svh"
module hsm_sticky_flag
  import hsm_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Flag carrier
  hsm_flag_if.owner fl
);
  hsm_flag_t s_ff;      // Registered state
  hsm_flag_t nxt_s;     // Next state

  // Hold, clear, or set; set has priority
  always_comb
  begin
    nxt_s = s_ff;
    if (fl.set)
    begin
      nxt_s.flag = 1'b1;
    end
    else if (fl.clr)
    begin
      nxt_s.flag = 1'b0;
    end
  end

  // Register with synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign fl.flag = s_ff.flag;
endmodule

// File: src/hsm_readback.sv
// Serial readback, command and alert status logic of the hot swap monitor
// Summary of operation
// R01: Software off bit forces hot swap off
// R02: Three readback modes set byte count
// R03: Combined read: V high, I high, nibbles
// R04: Voltage read: V high, V low nibble
// R05: Current read: I high, I low nibble
// R06: Three-byte read acked twice, then nack
// R07: Master reads two bytes in single mode
// R08: Status read returns one status byte
// R09: Bit 0: last three conversions over threshold
// R10: Bit 1: sticky digital overcurrent alert
// R11: Bit 2: off from analog overcurrent; failure flag on latch-off parts with the HS alert enabled
// R12: Bit 3: sticky hot swap failure
// R13: Bit 4: off input or software off
// R14: Bit 5: sticky off alert
// R15: Clear bit clears sticky bits 1,3,5
// R16: Software scales voltage code by range
// R17: Software scales current code by sense
// R18: Status-read command selects status byte
// R19: Single conversion nacks reads, self-clears
// R20: Continuous mode reads zero before first
// R21: Clear bit self-clears, source may reset
// R22: Status flags zero after reset
`timescale 1ns/1ps
`include "hsm_defines.svh"
module hsm_readback
  import hsm_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `HSM_SLAVE_ADDR
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Serial bus pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOeN,
  // Converter results
  input  wire logic [11:0] adcVoltage,
  input  wire logic        adcVoltDone,
  input  wire logic [11:0] adcCurrent,
  input  wire logic        adcCurDone,
  // Hot swap side
  input  wire logic        externalOnInput,
  input  wire logic        analogOvercurrentOff,
  input  wire logic        swapFailEvent,
  input  wire logic        retryVariant,
  output logic             hotSwapOn,
  output logic [6:0]       commandByte
);
  hsm_core_t s_ff;        // Registered state
  hsm_core_t nxt_s;       // Next state
  logic      sclRise;     // Clock edges and bus conditions
  logic      sclFall;
  logic      startCond;
  logic      stopCond;
  logic      offCond;     // Hot swap off request
  logic      vMode;       // Voltage selected
  logic      iMode;       // Current selected
  logic [11:0] vOut;      // Voltage as read back
  logic [11:0] iOut;      // Current as read back
  logic [7:0]  statusByte;
  logic [7:0]  loadByte;  // Byte to send for rdIdx
  logic [1:0]  lastIdx;   // Index of the final byte
  logic        exceed;    // Current above threshold
  logic        clearPulse;

  // Sticky flags
  hsm_flag_if flagIf [`HSM_NUM_FLAGS] ();
  genvar g;
  generate
    for (g = 0; g < `HSM_NUM_FLAGS; g++)
    begin : gFlag
      hsm_sticky_flag uFlag (
        .core_clk (core_clk),
        .nrst     (nrst),
        .fl       (flagIf[g])
      );
      assign flagIf[g].clr = clearPulse;  // see R15
    end
  endgenerate

  // Bus conditions from sampled pins
  assign sclRise   = sclIn & ~s_ff.sclQ;
  assign sclFall   = ~sclIn & s_ff.sclQ;
  assign startCond = sclIn & s_ff.sclQ & s_ff.sdaQ & ~sdaIn;
  assign stopCond  = sclIn & s_ff.sclQ & ~s_ff.sdaQ & sdaIn;

  // Off request from input or software bit
  assign offCond = ~externalOnInput | s_ff.software_force_off;  // see R01

  // Mode decode and zero before first result
  assign vMode = s_ff.cmd[`HSM_CMD_V_CONT] | s_ff.cmd[`HSM_CMD_V_ONCE];  // see R02
  assign iMode = s_ff.cmd[`HSM_CMD_I_CONT] | s_ff.cmd[`HSM_CMD_I_ONCE];
  assign vOut  = s_ff.vValid ? s_ff.vData : 12'h000;  // see R20
  assign iOut  = s_ff.iValid ? s_ff.iData : 12'h000;
  assign exceed = (adcCurrent[11:4] > s_ff.alertTh);
  assign clearPulse = s_ff.alertEn[`HSM_AEN_CLEAR];

  // Status byte
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[`HSM_ST_DIGITAL_OVERCURRENT_LIVE]    = s_ff.adcOc;  // see R09
    statusByte[`HSM_ST_ADC_ALERT] = flagIf[`HSM_FLAG_ADC].flag;  // see R10
    // Latch-off parts mirror the failure flag when enabled
    if (!retryVariant && s_ff.alertEn[`HSM_AEN_HS])
      statusByte[`HSM_ST_ANALOG_OVERCURRENT_OFF] = flagIf[`HSM_FLAG_HS].flag;  // see R11
    else
      statusByte[`HSM_ST_ANALOG_OVERCURRENT_OFF] = analogOvercurrentOff;
    statusByte[`HSM_ST_SWAP_FAILURE_STICKY]  = flagIf[`HSM_FLAG_HS].flag;  // see R12
    statusByte[`HSM_ST_OFF]       = offCond;  // see R13
    statusByte[`HSM_ST_OFF_ALERT] = flagIf[`HSM_FLAG_OFF].flag;  // see R14
  end

  // Byte packing per mode
  always_comb
  begin
    loadByte = 8'h00;
    lastIdx  = 2'd1;
    if (s_ff.cmd[`HSM_CMD_STATUS_RD])
    begin
      loadByte = statusByte;  // see R18
      lastIdx  = 2'd0;
    end
    else if (vMode && !iMode)
    begin
      // Voltage alone
      loadByte = (s_ff.rdIdx == 2'd0) ? vOut[11:4] : {vOut[3:0], 4'h0};  // see R04
    end
    else if (iMode && !vMode)
    begin
      // Current alone
      loadByte = (s_ff.rdIdx == 2'd0) ? iOut[11:4] : {iOut[3:0], 4'h0};  // see R05
    end
    else
    begin
      // Combined, also used when nothing is selected
      lastIdx = 2'd2;
      unique case (s_ff.rdIdx)
        2'd0:    loadByte = vOut[11:4];  // see R03
        2'd1:    loadByte = iOut[11:4];
        default: loadByte = {vOut[3:0], iOut[3:0]};
      endcase
    end
  end

  // Sticky flag sources
  assign flagIf[`HSM_FLAG_ADC].set = adcCurDone & ((s_ff.alertEn[`HSM_AEN_OC1] & exceed) |
    (s_ff.alertEn[`HSM_AEN_OC4] & exceed & (&s_ff.ocHist)));  // see R10
  assign flagIf[`HSM_FLAG_HS].set  = swapFailEvent;  // see R12
  assign flagIf[`HSM_FLAG_OFF].set = offCond & ~s_ff.offPrev &
    s_ff.alertEn[`HSM_AEN_OFF];  // see R14

  // Next state: serial slave, registers and monitors
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sclQ      = sclIn;
    nxt_s.sdaQ      = sdaIn;
    nxt_s.offPrev   = offCond;
    nxt_s.hotSwapOn = ~offCond;  // see R01
    // Clear bit returns to zero after one cycle
    nxt_s.alertEn[`HSM_AEN_CLEAR] = 1'b0;  // see R21
    // Capture results and retire single conversions
    if (adcVoltDone)
    begin
      nxt_s.vData  = adcVoltage;
      nxt_s.vValid = 1'b1;
      nxt_s.cmd[`HSM_CMD_V_ONCE] = 1'b0;  // see R19
    end
    if (adcCurDone)
    begin
      nxt_s.iData  = adcCurrent;
      nxt_s.iValid = 1'b1;
      nxt_s.cmd[`HSM_CMD_I_ONCE] = 1'b0;  // see R19
      nxt_s.ocHist = {s_ff.ocHist[1:0], exceed};
      nxt_s.adcOc  = exceed & s_ff.ocHist[1] & s_ff.ocHist[0];  // see R09
    end
    nxt_s.onceBusy = nxt_s.cmd[`HSM_CMD_V_ONCE] | nxt_s.cmd[`HSM_CMD_I_ONCE];
    // Serial slave
    if (startCond)
    begin
      nxt_s.st     = HSM_ADDR;
      nxt_s.bitCnt = 4'd0;
      nxt_s.sdaOeN = 1'b1;
    end
    else if (stopCond)
    begin
      nxt_s.st     = HSM_IDLE;
      nxt_s.sdaOeN = 1'b1;
    end
    else
    begin
      unique case (s_ff.st)
        HSM_IDLE:
        begin
          nxt_s.sdaOeN = 1'b1;
        end
        HSM_ADDR, HSM_WR:
        begin
          // Shift in on rise, decide on the fall after bit 8
          if (sclRise && s_ff.bitCnt < 4'd8)
          begin
            nxt_s.shift  = {s_ff.shift[6:0], sdaIn};
            nxt_s.bitCnt = s_ff.bitCnt + 4'd1;
          end
          else if (sclFall && s_ff.bitCnt == 4'd8)
          begin
            nxt_s.st     = HSM_ACK;
            nxt_s.sdaOeN = 1'b0;
            if (s_ff.st == HSM_ADDR)
            begin
              nxt_s.rw    = s_ff.shift[0];
              nxt_s.wrIdx = 1'b0;
              nxt_s.rdIdx = 2'd0;
              // Foreign address, or read during single conversion
              if (s_ff.shift[7:1] != SLAVE_ADDR || (s_ff.shift[0] && s_ff.onceBusy))
              begin
                nxt_s.st     = HSM_IDLE;  // see R19
                nxt_s.sdaOeN = 1'b1;
              end
            end
            else if (!s_ff.wrIdx)
            begin
              nxt_s.wrIdx = 1'b1;
              if (s_ff.shift[`HSM_CMD_EXT_BIT])
              begin
                nxt_s.extSel = s_ff.shift[1:0];
              end
              else
              begin
                // Command byte restarts readiness of results
                nxt_s.extSel   = 2'd0;
                nxt_s.cmd      = s_ff.shift[6:0];
                nxt_s.vValid   = 1'b0;  // see R20
                nxt_s.iValid   = 1'b0;
                nxt_s.onceBusy = s_ff.shift[`HSM_CMD_V_ONCE] | s_ff.shift[`HSM_CMD_I_ONCE];
              end
            end
            else
            begin
              // Extended register data, once per transfer
              nxt_s.extSel = 2'd0;
              unique case (s_ff.extSel)
                `HSM_SEL_ALERT_EN: nxt_s.alertEn = s_ff.shift[4:0];  // see R15
                `HSM_SEL_ALERT_TH: nxt_s.alertTh = s_ff.shift;
                `HSM_SEL_CONTROL:  nxt_s.software_force_off   = s_ff.shift[`HSM_CTL_SOFTWARE_FORCE_OFF];
                default:           nxt_s.extSel  = 2'd0;
              endcase
            end
          end
        end
        HSM_ACK:
        begin
          // Release acknowledge; a read drives its first bit
          if (sclFall)
          begin
            nxt_s.bitCnt = 4'd0;
            nxt_s.sdaOeN = 1'b1;
            nxt_s.st     = HSM_WR;
            if (s_ff.rw)
            begin
              nxt_s.st     = HSM_RD;  // see R06
              nxt_s.shift  = {loadByte[6:0], 1'b0};
              nxt_s.sdaOeN = loadByte[7];
              nxt_s.bitCnt = 4'd1;
            end
          end
        end
        HSM_RD:
        begin
          // Drive one bit per falling edge
          if (sclFall)
          begin
            if (s_ff.bitCnt == 4'd8)
            begin
              nxt_s.sdaOeN = 1'b1;
              nxt_s.st     = HSM_RDACK;
            end
            else
            begin
              nxt_s.sdaOeN = s_ff.shift[7];
              nxt_s.shift  = {s_ff.shift[6:0], 1'b0};
              nxt_s.bitCnt = s_ff.bitCnt + 4'd1;
            end
          end
        end
        HSM_RDACK:
        begin
          // Master ack continues, nack ends the read
          if (sclRise)
          begin
            nxt_s.rw = ~sdaIn;
            if (s_ff.rdIdx != lastIdx)
              nxt_s.rdIdx = s_ff.rdIdx + 2'd1;  // see R07
          end
          else if (sclFall)
          begin
            nxt_s.st = HSM_IDLE;
            if (s_ff.rw)
            begin
              nxt_s.st     = HSM_RD;  // see R08
              nxt_s.shift  = {loadByte[6:0], 1'b0};
              nxt_s.sdaOeN = loadByte[7];
              nxt_s.bitCnt = 4'd1;
            end
          end
        end
      endcase
    end
  end

  // State register; flags and software off reset to zero, alert enable to 04 and threshold to FF
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_ff         <= '0;  // see R22
      s_ff.st      <= HSM_IDLE;
      s_ff.sclQ    <= 1'b1;
      s_ff.sdaQ    <= 1'b1;
      s_ff.sdaOeN  <= 1'b1;
      s_ff.cmd     <= `HSM_CMD_RESET;
      s_ff.alertEn <= `HSM_AEN_RESET;
      s_ff.alertTh <= `HSM_ATH_RESET;
      s_ff.offPrev <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign sdaOut      = 1'b0;
  assign sdaOeN      = s_ff.sdaOeN;
  assign hotSwapOn   = s_ff.hotSwapOn;
  assign commandByte = s_ff.cmd;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence ackSlot;
    (s_ff.st == HSM_ACK) && !s_ff.sdaOeN;
  endsequence
  sequence readFirstBit;
    (s_ff.st == HSM_RD) && (s_ff.bitCnt == 4'd1);
  endsequence

  software_force_off_forces_a: assert property (s_ff.software_force_off |=> !hotSwapOn)  // see R01
    else $error("software off did not stop hot swap");
  off_status_a: assert property (statusByte[`HSM_ST_OFF] == (!externalOnInput || s_ff.software_force_off))  // see R13
    else $error("off status wrong");
  clear_flags_a: assert property (clearPulse && !swapFailEvent |=> !flagIf[`HSM_FLAG_HS].flag)  // see R15
    else $error("clear left failure flag set");
  clear_self_a: assert property (clearPulse |=> !clearPulse)  // see R21
    else $error("clear bit did not self clear");
  busy_nack_a: assert property (((s_ff.st == HSM_ADDR) && sclFall && (s_ff.bitCnt == 4'd8)
    && s_ff.shift[0] && s_ff.onceBusy) |=> (s_ff.st == HSM_IDLE) && s_ff.sdaOeN)  // see R19
    else $error("read acknowledged during single conversion");
  zero_before_a: assert property (!s_ff.vValid |-> (vOut == 12'h000))  // see R20
    else $error("voltage not zero before first result");
  combined_lsb_a: assert property ((vMode == iMode) && !s_ff.cmd[`HSM_CMD_STATUS_RD]
    && (s_ff.rdIdx == 2'd2) |-> (loadByte == {vOut[3:0], iOut[3:0]}))  // see R03
    else $error("combined low byte packed wrong");
  single_lsb_a: assert property (vMode && !iMode && !s_ff.cmd[`HSM_CMD_STATUS_RD]
    && (s_ff.rdIdx == 2'd1) |-> (loadByte[3:0] == 4'h0))  // see R04
    else $error("voltage low nibble not zero");
  ack_then_read_a: assert property (ackSlot ##0 (s_ff.rw && sclFall && !startCond && !stopCond)
    |=> readFirstBit)  // see R06
    else $error("read did not start after acknowledge");
  oc_live_a: assert property (adcCurDone && exceed && (&s_ff.ocHist[1:0]) |=> s_ff.adcOc)  // see R09
    else $error("three overcurrent results not reported");
  status_sel_a: assert property (s_ff.cmd[`HSM_CMD_STATUS_RD] |-> (loadByte == statusByte))  // see R18
    else $error("status byte not selected");
endmodule

// File: tb/hsm_i2c_master.sv
// Serial bus master model that drives the readback block's pins
`timescale 1ns/1ps
module hsm_i2c_master
(
  // Clock
  input  wire logic core_clk,
  // Bus wires
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaDrv
);
  // Idle bus, both lines released high
  initial
  begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end

  // Wait on core clock falls
  task automatic waitClk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Start or repeated start, data falls while clock high
  task automatic startCond();
    sdaDrv = 1'b1;
    waitClk(2);
    sclOut = 1'b1;
    waitClk(4);
    sdaDrv = 1'b0;
    waitClk(4);
    sclOut = 1'b0;
    waitClk(2);
  endtask

  // Stop, data rises while clock high
  task automatic stopCond();
    sdaDrv = 1'b0;
    waitClk(2);
    sclOut = 1'b1;
    waitClk(4);
    sdaDrv = 1'b1;
    waitClk(4);
  endtask

  // One clock pulse; data held over the whole high phase
  task automatic bitCycle(input logic b, output logic s);
    sdaDrv = b;
    waitClk(4);
    sclOut = 1'b1;
    waitClk(2);
    s = sdaWire;
    waitClk(2);
    sclOut = 1'b0;
    waitClk(1);
  endtask

  // Send a byte, MSB first, then release for the slave's answer
  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--)
      bitCycle(d[k], s);
    bitCycle(1'b1, s);
    ack = !s;
  endtask

  // Receive a byte, then acknowledge or refuse it
  task automatic byteIn(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int k = 7; k >= 0; k--)
      bitCycle(1'b1, d[k]);
    bitCycle(!ackIt, s);
  endtask
endmodule

// File: tb/tb_hsm_readback.sv
// Self-checking bench for the hot swap monitor readback block
`timescale 1ns/1ps
module tb_hsm_readback;
  localparam logic [6:0] DEV_ADDR = 7'h2B;  // Non-default address
  logic        core_clk;
  logic        nrst;
  logic        sclIn;
  logic        sdaDrv;
  logic        sdaWire;
  logic        sdaOut;
  logic        sdaOeN;
  logic [11:0] adcVoltage;
  logic        adcVoltDone;
  logic [11:0] adcCurrent;
  logic        adcCurDone;
  logic        externalOnInput;
  logic        analogOvercurrentOff;
  logic        swapFailEvent;
  logic        retryVariant;
  logic        hotSwapOn;
  logic [6:0]  commandByte;
  int          numErrors;
  int          cmpCount;
  int          cycles;

  // Open-drain data wire with pull-up
  assign sdaWire = sdaDrv & (sdaOeN | sdaOut);

  hsm_readback #(.SLAVE_ADDR(DEV_ADDR)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .adcVoltage(adcVoltage),
    .adcVoltDone(adcVoltDone), .adcCurrent(adcCurrent), .adcCurDone(adcCurDone),
    .externalOnInput(externalOnInput), .analogOvercurrentOff(analogOvercurrentOff),
    .swapFailEvent(swapFailEvent), .retryVariant(retryVariant),
    .hotSwapOn(hotSwapOn), .commandByte(commandByte));

  hsm_i2c_master m_u (.core_clk(core_clk), .sdaWire(sdaWire), .sclOut(sclIn),
    .sdaDrv(sdaDrv));

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      numErrors++;
      stop_test();
    end
  end

  // Compare seen against expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected readback byte for a command and a result pair
  function automatic logic [7:0] expByte(input logic [6:0] c, input logic [11:0] v,
                                         input logic [11:0] i, input int k);
    logic vOnly;
    logic iOnly;
    vOnly = (c[0] | c[1]) & !(c[2] | c[3]);
    iOnly = (c[2] | c[3]) & !(c[0] | c[1]);
    if (vOnly)
      return (k == 0) ? v[11:4] : {v[3:0], 4'h0};
    if (iOnly)
      return (k == 0) ? i[11:4] : {i[3:0], 4'h0};
    return (k == 0) ? v[11:4] : (k == 1) ? i[11:4] : {v[3:0], i[3:0]};
  endfunction

  // Write one or two bytes after the address
  task automatic wrBytes(input logic [7:0] b0, input logic [7:0] b1, input int n);
    logic a;
    m_u.startCond();
    m_u.byteOut({DEV_ADDR, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    m_u.byteOut(b0, a);
    if (n > 1)
      m_u.byteOut(b1, a);
    m_u.stopCond();
  endtask

  // Read n bytes, acknowledging all but the last
  task automatic rdBytes(input int n, output logic [7:0] d [3], output logic a);
    m_u.startCond();
    m_u.byteOut({DEV_ADDR, 1'b1}, a);
    if (a)
      for (int k = 0; k < n; k++)
        m_u.byteIn(k < n - 1, d[k]);
    m_u.stopCond();
  endtask

  // Status byte acknowledged, then repeated once and refused
  task automatic rdStatus(input logic [7:0] exp);
    logic [7:0] d [3];
    logic       a;
    rdBytes(2, d, a);
    check(d[0], exp);
    check(d[1], exp);
  endtask

  // One conversion result on both channels
  task automatic pulseAdc(input logic [11:0] v, input logic [11:0] i);
    adcVoltage = v;
    adcCurrent = i;
    adcVoltDone = 1'b1;
    adcCurDone = 1'b1;
    @(negedge core_clk);
    adcVoltDone = 1'b0;
    adcCurDone = 1'b0;
    @(negedge core_clk);
  endtask

  // Main sequence
  initial
  begin
    logic [6:0]  modes [4];
    logic [7:0]  d [3];
    logic        a;
    logic [11:0] v;
    logic [11:0] i;
    int          n;
    modes = '{7'h05, 7'h01, 7'h04, 7'h00};
    nrst = 1'b0;
    adcVoltage = 12'h000;
    adcVoltDone = 1'b0;
    adcCurrent = 12'h000;
    adcCurDone = 1'b0;
    externalOnInput = 1'b1;
    analogOvercurrentOff = 1'b0;
    swapFailEvent = 1'b0;
    retryVariant = 1'b0;
    void'($urandom(39301));
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    check({7'h00, hotSwapOn}, 8'h01);
    check({1'b0, commandByte}, 8'h00);
    wrBytes(8'h40, 8'h00, 1);
    rdStatus(8'h00);
    // Foreign address is refused
    m_u.startCond();
    m_u.byteOut({~DEV_ADDR, 1'b1}, a);
    m_u.stopCond();
    check({7'h00, a}, 8'h00);
    // Every readback mode, zero before the first result
    for (int m = 0; m < 4; m++)
    begin
      n = (modes[m] == 7'h01 || modes[m] == 7'h04) ? 2 : 3;
      wrBytes({1'b0, modes[m]}, 8'h00, 1);
      check({1'b0, commandByte}, {1'b0, modes[m]});
      rdBytes(n, d, a);
      check(d[0], 8'h00);
      v = (m == 3) ? 12'hFFF : 12'($urandom);
      i = (m == 3) ? 12'h001 : 12'($urandom);
      pulseAdc(v, i);
      rdBytes(n, d, a);
      for (int k = 0; k < n; k++)
        check(d[k], expByte(modes[m], v, i, k));
      // Low nibble of the code intact, so software can scale the full code
      if (m == 1)
        check({d[1][7:4], 4'h0}, {v[3:0], 4'h0});
      if (m == 2)
        check({d[1][7:4], 4'h0}, {i[3:0], 4'h0});
    end
    // Single conversions refuse reads until done, then self-clear
    for (int m = 0; m < 2; m++)
    begin
      wrBytes((m == 0) ? 8'h02 : 8'h08, 8'h00, 1);
      rdBytes(1, d, a);
      check({7'h00, a}, 8'h00);
      pulseAdc(12'($urandom), 12'($urandom));
      check({1'b0, commandByte}, 8'h00);
      rdBytes(1, d, a);
      check({7'h00, a}, 8'h01);
    end
    // Digital overcurrent against a lowered threshold
    wrBytes(8'h40, 8'h00, 1);
    wrBytes(8'h82, 8'h10, 2);
    wrBytes(8'h81, 8'h05, 2);
    for (int k = 0; k < 3; k++)
      pulseAdc(12'h000, {8'h11 + 8'($urandom % 238), 4'($urandom)});
    rdStatus(8'h03);
    pulseAdc(12'h000, {4'h0, 8'($urandom)});
    rdStatus(8'h02);
    wrBytes(8'h81, 8'h15, 2);
    rdStatus(8'h00);
    // Software off, failure, clear, retry part
    wrBytes(8'h81, 8'h0C, 2);
    wrBytes(8'h83, 8'h01, 2);
    check({7'h00, hotSwapOn}, 8'h00);
    rdStatus(8'h30);
    swapFailEvent = 1'b1;
    @(negedge core_clk);
    swapFailEvent = 1'b0;
    rdStatus(8'h3C);
    wrBytes(8'h81, 8'h1C, 2);
    rdStatus(8'h10);
    retryVariant = 1'b1;
    analogOvercurrentOff = 1'b1;
    rdStatus(8'h14);
    analogOvercurrentOff = 1'b0;
    // Off by the external input
    wrBytes(8'h83, 8'h00, 2);
    externalOnInput = 1'b0;
    repeat (3) @(negedge core_clk);
    check({7'h00, hotSwapOn}, 8'h00);
    rdStatus(8'h30);
    externalOnInput = 1'b1;
    repeat (3) @(negedge core_clk);
    check({7'h00, hotSwapOn}, 8'h01);
    rdStatus(8'h20);
    stop_test();
  end
endmodule
